// *** src/tfs_device.sv ***
/*
  Device end: 8-bit configuration registers of the transceiver with
  reset defaults and decoded datapath settings.
  Assumes the host keeps the configuration write order and pin inputs
  from outside aclk are synchronised here.
*/
// Summary of operation
// - Reset gives SF, B8ZS receive, AMI transmit
// - Transmit line, clock, data, pulse held low
// - Receive backplane 1.544, tristate, pins inputs
// - Transmit backplane 1.544, data on, signaling off
// - Transmit store bypassed, receive store used
// - Diagnostics off, monitor counts out-of-frame
// - Decoder 00H B8ZS, 80H AMI
// - Elastic stores 00H give 193-bit frames
// - Transmitter 3XH gives B8ZS ESF
// - Transmitter 00H SF, 08H loop format
// - Transmitter 04H or 0CH gives T1DM
// - Framer 1X/5X/9X ESF with thresholds
// - Host matches framer and transmitter nibbles
// - Framer SF and loop format codes
// - Framer 04H T1DM, 4 of 12
// - Code detector 00H 8/10, 02H 4/5
// - Alarm integrator ESF, SF, loop codes
// - Alarm integrator T1DM standard or alternate red
// - Loopback detector enable and patterns
// - Signaling extractor 04H ESF, else 00H
`default_nettype none
module tfs_device
  import tfs_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Configuration port
  tfs_cfg_if.device        cfg,
  // Transmit line side, user sources
  input  wire logic [1:0]  tx_line_pos_src,
  input  wire logic [1:0]  tx_line_neg_src,
  input  wire logic        tx_clock_src,
  input  wire logic        tx_data_src,
  input  wire logic        tx_frame_pulse_src,
  output logic      [1:0]  tx_line_pos,
  output logic      [1:0]  tx_line_neg,
  output logic             tx_clock_out,
  output logic             tx_data_out,
  output logic             tx_frame_pulse_out,
  // Backplane pins
  input  wire logic        rx_backplane_frame_pulse_in,
  input  wire logic        rx_backplane_clock_in,
  input  wire logic        tx_backplane_frame_pulse_in,
  input  wire logic        tx_backplane_clock_in,
  output logic             rx_backplane_data_oe,
  output logic             rx_backplane_signaling_oe,
  output logic             rx_backplane_frame_pulse_oe,
  output logic             rx_backplane_clock_oe,
  output logic             tx_backplane_frame_pulse_oe,
  output logic             tx_backplane_clock_oe,
  output logic      [3:0]  backplane_pins_sync,
  output logic      [1:0]  backplane_rate,
  output logic             tx_backplane_data_active,
  output logic             tx_backplane_signaling_active,
  // Decoded settings
  output logic             rx_line_ami,
  output logic             rx_elastic_frame193,
  output logic             tx_elastic_frame193,
  output logic             rx_elastic_bypass,
  output logic             tx_elastic_bypass,
  output logic             tx_signaling_align,
  output logic             tx_fcrc_fdl_bypass,
  output logic             rx_data_link_enable,
  output logic             tx_data_link_enable,
  output logic             diagnostics_enable,
  output logic             monitor_counts_frame_alignment_change,
  output tfs_format_t      tx_format,
  output logic             tx_line_b8zs,
  output logic      [3:0]  tx_fdl_option,
  output tfs_format_t      framer_format,
  output tfs_oof_t         framer_oof,
  output logic      [3:0]  framer_fdl_rate,
  output logic             bit_code_4of5,
  output tfs_format_t      alarm_format,
  output logic             alarm_alt_red,
  output logic      [3:0]  alarm_yellow_rate,
  output logic             loopback_detect_enable,
  output logic      [7:0]  loopback_activate,
  output logic      [7:0]  loopback_deactivate,
  output logic             signaling_esf
);
  localparam logic [7:0] MAP [NUM_CFG] = '{OFF_RX_LINE_DECODER, OFF_RX_ELASTIC,
    OFF_TX_ELASTIC, OFF_FRAMER, OFF_LB_DETECT, OFF_LB_ACTIVATE, OFF_LB_DEACTIVATE,
    OFF_SIG_EXTRACT, OFF_BASIC_TX, OFF_ALARM_INTEG, OFF_BIT_CODE};

  logic [7:0]         regs [NUM_CFG];
  logic [NUM_CFG-1:0] hit;
  logic [7:0]         next_rdata;
  logic               tx_hold;
  logic [3:0]         pin_meta;
  logic [3:0]         pin_sync;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CFG; gi++)
    begin : g_cfg
      assign hit[gi] = (cfg.addr == MAP[gi]);
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          regs[gi] <= CFG_RESET;
        else if (ce && cfg.wr && hit[gi])
          regs[gi] <= cfg.wdata;
      end
    end
  endgenerate

  always_comb
  begin
    next_rdata = 8'h00;
    for (int i = 0; i < NUM_CFG; i++)
      if (hit[i])
        next_rdata = regs[i];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg.rdata <= 8'h00;
    else if (ce && cfg.rd)
      cfg.rdata <= next_rdata;
  end

  // Line outputs stay low until the transmitter is configured
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_hold <= 1'b1;
    else if (ce && cfg.wr && hit[8])
      tx_hold <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_line_pos        <= 2'b00;
      tx_line_neg        <= 2'b00;
      tx_clock_out       <= 1'b0;
      tx_data_out        <= 1'b0;
      tx_frame_pulse_out <= 1'b0;
    end
    else if (ce)
    begin
      tx_line_pos        <= tx_hold ? 2'b00 : tx_line_pos_src;
      tx_line_neg        <= tx_hold ? 2'b00 : tx_line_neg_src;
      tx_clock_out       <= tx_clock_src & ~tx_hold;
      tx_data_out        <= tx_data_src & ~tx_hold;
      tx_frame_pulse_out <= tx_frame_pulse_src & ~tx_hold;
    end
  end

  // Backplane pins sampled as inputs, two stages
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end
    else if (ce)
    begin
      pin_meta <= {tx_backplane_clock_in, tx_backplane_frame_pulse_in,
                   rx_backplane_clock_in, rx_backplane_frame_pulse_in};
      pin_sync <= pin_meta;
    end
  end
  assign backplane_pins_sync         = pin_sync;
  assign backplane_rate              = 2'b00;
  assign rx_backplane_data_oe        = 1'b0;
  assign rx_backplane_signaling_oe   = 1'b0;
  assign rx_backplane_frame_pulse_oe = 1'b0;
  assign rx_backplane_clock_oe       = 1'b0;
  assign tx_backplane_frame_pulse_oe   = 1'b0;
  assign tx_backplane_clock_oe         = 1'b0;
  assign tx_backplane_data_active      = 1'b1;
  assign tx_backplane_signaling_active = 1'b0;
  assign rx_elastic_bypass   = 1'b0;
  assign tx_elastic_bypass   = 1'b1;
  assign tx_signaling_align  = 1'b0;
  assign tx_fcrc_fdl_bypass  = 1'b0;
  assign rx_data_link_enable = 1'b0;
  assign tx_data_link_enable = 1'b0;
  assign diagnostics_enable  = 1'b0;
  assign monitor_counts_frame_alignment_change = 1'b0;

  assign rx_line_ami = regs[0][7];
  assign rx_elastic_frame193 = (regs[1] == VAL_ZERO);
  assign tx_elastic_frame193 = (regs[2] == VAL_ZERO);

  assign tx_line_b8zs  = (regs[8][7:4] == VAL_TX_ESF_HI[7:4]);
  assign tx_fdl_option = regs[8][3:0];
  // SF and loop format; T1DM on 04H or 0CH
  assign tx_format = tx_line_b8zs ? TFS_FMT_ESF :
                     regs[8][2] ? TFS_FMT_T1DM :
                     regs[8][3] ? TFS_FMT_SLC : TFS_FMT_SF;

  wire fr_t1dm = (regs[3] == VAL_FR_T1DM);
  wire fr_esf  = regs[3][4];
  assign framer_format = fr_t1dm ? TFS_FMT_T1DM : fr_esf ? TFS_FMT_ESF :
                         regs[3][3] ? TFS_FMT_SLC : TFS_FMT_SF;
  assign framer_oof = fr_t1dm ? TFS_OOF_4OF12 :
                      regs[3][7] ? TFS_OOF_2OF6 :
                      regs[3][6] ? TFS_OOF_2OF5 : TFS_OOF_2OF4;
  // Nibble exported for comparison with the transmitter
  assign framer_fdl_rate = fr_esf ? regs[3][3:0] : 4'h0;

  assign bit_code_4of5 = regs[10][1];

  assign alarm_yellow_rate = regs[9][4] ? regs[9][3:0] : 4'h0;
  assign alarm_alt_red = ~regs[9][4] & regs[9][2] & regs[9][3];
  assign alarm_format  = regs[9][4] ? TFS_FMT_ESF : regs[9][2] ? TFS_FMT_T1DM :
                         regs[9][3] ? TFS_FMT_SLC : TFS_FMT_SF;

  assign loopback_detect_enable = (regs[4] == VAL_ZERO);
  assign loopback_activate      = regs[5];
  assign loopback_deactivate    = regs[6];
  assign signaling_esf = regs[7][2];
endmodule
`default_nettype wire

// *** src/tfs_pkg.sv ***
/*
  Shared constants for the T1 framing-format setup: the 8-bit
  configuration map of the transceiver, the reset values, the field
  codes and the controller's own AXI4-Lite register map.
  Assumes a single aclk domain on both ends.
*/
`default_nettype none
package tfs_pkg;
  // Device configuration offsets
  localparam logic [7:0] OFF_RX_LINE_DECODER = 8'h10;
  localparam logic [7:0] OFF_RX_ELASTIC      = 8'h1c;
  localparam logic [7:0] OFF_TX_ELASTIC      = 8'h20;
  localparam logic [7:0] OFF_FRAMER          = 8'h48;
  localparam logic [7:0] OFF_LB_DETECT       = 8'h4c;
  localparam logic [7:0] OFF_LB_ACTIVATE     = 8'h4e;
  localparam logic [7:0] OFF_LB_DEACTIVATE   = 8'h4f;
  localparam logic [7:0] OFF_SIG_EXTRACT     = 8'h50;
  localparam logic [7:0] OFF_BASIC_TX        = 8'h54;
  localparam logic [7:0] OFF_ALARM_INTEG     = 8'h60;
  localparam logic [7:0] OFF_BIT_CODE        = 8'h6a;
  localparam int         NUM_CFG             = 11;
  localparam logic [7:0] CFG_RESET           = 8'h00;

  // Values written by the controller
  localparam logic [7:0] VAL_ZERO            = 8'h00;
  localparam logic [7:0] VAL_AMI_DECODE      = 8'h80;
  localparam logic [7:0] VAL_TX_ESF_HI       = 8'h30;
  localparam logic [7:0] VAL_TX_SLC          = 8'h08;
  localparam logic [7:0] VAL_TX_T1DM         = 8'h04;
  localparam logic [7:0] VAL_TX_T1DM_ALT     = 8'h0c;
  localparam logic [7:0] VAL_FR_ESF_HI       = 8'h10;
  localparam logic [7:0] VAL_FR_SLC          = 8'h08;
  localparam logic [7:0] VAL_FR_T1DM         = 8'h04;
  localparam logic [7:0] VAL_BOC_4OF5        = 8'h02;
  localparam logic [7:0] VAL_AL_ESF_HI       = 8'h10;
  localparam logic [7:0] VAL_SIG_ESF         = 8'h04;
  localparam logic [7:0] VAL_LB_ACTIVATE     = 8'h08;
  localparam logic [7:0] VAL_LB_DEACTIVATE   = 8'h44;

  // Controller AXI4-Lite map
  localparam logic [7:0] AXI_CTRL            = 8'h00;
  localparam logic [7:0] AXI_STATUS          = 8'h04;
  localparam int         CTRL_START_BIT      = 31;
  localparam logic [1:0] RESP_OKAY           = 2'b00;
  localparam logic [1:0] RESP_SLVERR         = 2'b10;

  typedef enum logic [1:0] {
    TFS_FMT_ESF  = 2'b00,
    TFS_FMT_SLC  = 2'b01,
    TFS_FMT_SF   = 2'b10,
    TFS_FMT_T1DM = 2'b11
  } tfs_format_t;

  // Out-of-frame threshold codes: 2/4, 2/5, 2/6, 4/12
  typedef enum logic [1:0] {
    TFS_OOF_2OF4  = 2'b00,
    TFS_OOF_2OF5  = 2'b01,
    TFS_OOF_2OF6  = 2'b10,
    TFS_OOF_4OF12 = 2'b11
  } tfs_oof_t;
endpackage
`default_nettype wire

// *** src/tfs_if.sv ***
/*
  Configuration port between the controller and the device end.
  One-cycle write strobe, read data one cycle after the read strobe.
*/
`default_nettype none
interface tfs_cfg_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  modport device (input addr, input wdata, input wr, input rd, output rdata);
  modport host   (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// *** src/tfs_host.sv ***
/*
  Controller end: AXI4-Lite slave taking a format order, then writing
  the framing-format sequence over the configuration port.
  Assumes the device accepts one write per enabled cycle.
*/
`default_nettype none
module tfs_host
  import tfs_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Configuration port
  tfs_cfg_if.host          cfg
);
  logic [9:0]  ctrl;
  logic        busy;
  logic        done;
  logic [3:0]  step;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire tfs_format_t fmt   = tfs_format_t'(ctrl[1:0]);
  wire [7:0]        oofhi = {ctrl[3:2], 6'b000000};
  wire [3:0]        nib   = ctrl[7:4];
  wire              do_wr = aw_held && w_held && !s_axi_bvalid;
  wire              ctrl_hit  = (aw_addr == AXI_CTRL);
  wire              start     = do_wr && ctrl_hit && w_strb[3] && w_data[CTRL_START_BIT] && !busy;

  // One nibble to transmitter, framer, alarm
  // Sequence entry: {skip, address, data}
  function automatic logic [16:0] entry(input logic [3:0] s);
    logic [16:0] e;
    e = {1'b0, OFF_RX_LINE_DECODER, (fmt == TFS_FMT_ESF) ? VAL_ZERO : VAL_AMI_DECODE};
    case (s)
      4'h1: e = {1'b0, OFF_RX_ELASTIC, VAL_ZERO};
      4'h2: e = {1'b0, OFF_TX_ELASTIC, VAL_ZERO};
      4'h3: e = {1'b0, OFF_BASIC_TX, fmt == TFS_FMT_ESF ? (VAL_TX_ESF_HI | {4'h0, nib}) :
                 fmt == TFS_FMT_SLC ? VAL_TX_SLC :
                 fmt == TFS_FMT_T1DM ? (ctrl[9] ? VAL_TX_T1DM_ALT : VAL_TX_T1DM) : VAL_ZERO};
      4'h4: e = {1'b0, OFF_FRAMER, fmt == TFS_FMT_ESF ? (VAL_FR_ESF_HI | oofhi | {4'h0, nib}) :
                 fmt == TFS_FMT_SLC ? (VAL_FR_SLC | oofhi) :
                 fmt == TFS_FMT_T1DM ? VAL_FR_T1DM : oofhi};
      4'h5: e = {fmt != TFS_FMT_ESF, OFF_BIT_CODE, ctrl[8] ? VAL_BOC_4OF5 : VAL_ZERO};
      4'h6: e = {1'b0, OFF_ALARM_INTEG, fmt == TFS_FMT_ESF ? (VAL_AL_ESF_HI | {4'h0, nib}) :
                 fmt == TFS_FMT_SLC ? VAL_TX_SLC :
                 fmt == TFS_FMT_T1DM ? (ctrl[9] ? VAL_TX_T1DM_ALT : VAL_TX_T1DM) : VAL_ZERO};
      4'h7: e = {1'b0, OFF_LB_DETECT, VAL_ZERO};
      4'h8: e = {1'b0, OFF_LB_ACTIVATE, VAL_LB_ACTIVATE};
      4'h9: e = {1'b0, OFF_LB_DEACTIVATE, VAL_LB_DEACTIVATE};
      4'ha: e = {1'b0, OFF_SIG_EXTRACT, fmt == TFS_FMT_ESF ? VAL_SIG_ESF : VAL_ZERO};
      default: e = e;
    endcase
    return e;
  endfunction

  wire [16:0] cur = entry(step);

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      ctrl <= 10'h000;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (ctrl_hit || aw_addr == AXI_STATUS) ? RESP_OKAY : RESP_SLVERR;
        // Order is frozen while a sequence runs
        if (ctrl_hit && !busy)
        begin
          if (w_strb[0])
            ctrl[7:0] <= w_data[7:0];
          if (w_strb[1])
            ctrl[9:8] <= w_data[9:8];
        end
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && !s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        if (s_axi_araddr == AXI_CTRL)
          s_axi_rdata <= {22'h0, ctrl};
        else if (s_axi_araddr == AXI_STATUS)
          s_axi_rdata <= {30'h0, done, busy};
        else
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // One configuration write per cycle while busy, none on the code detector step outside ESF
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      step <= 4'h0;
      cfg.wr    <= 1'b0;
      cfg.addr  <= 8'h00;
      cfg.wdata <= 8'h00;
    end
    else if (ce)
    begin
      cfg.wr <= 1'b0;
      if (start)
      begin
        busy <= 1'b1;
        done <= 1'b0;
        step <= 4'h0;
      end
      else if (busy)
      begin
        cfg.wr    <= !cur[16];
        cfg.addr  <= cur[15:8];
        cfg.wdata <= cur[7:0];
        step <= step + 4'h1;
        if (step == 4'ha)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  assign cfg.rd = 1'b0;
endmodule
`default_nettype wire

// *** tb/tfs_assertions.sv ***
/*
  Checker for the configuration port between controller and device end.
  Assumes ce held high, so the controller writes on consecutive cycles.
*/
`default_nettype none
module tfs_assertions
  import tfs_pkg::*;
(
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Configuration port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] fr_seen;
  wire        wr_fr = wr && addr == OFF_FRAMER;
  // Framer code kept to judge the later entries
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fr_seen <= 8'h00;
    else if (wr_fr)
      fr_seen <= wdata;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_order;
    wr && addr == OFF_RX_LINE_DECODER |=> wr && addr == OFF_RX_ELASTIC ##1
      wr && addr == OFF_TX_ELASTIC ##1 wr && addr == OFF_BASIC_TX ##1 wr_fr;
  endproperty
  a_order: assert property (p_order) else $error("config order broken");
  property p_decoder;
    wr && addr == OFF_RX_LINE_DECODER |-> wdata == 8'h00 || wdata == 8'h80;
  endproperty
  a_decoder: assert property (p_decoder) else $error("bad decoder code");
  property p_elastic;
    wr && (addr == OFF_RX_ELASTIC || addr == OFF_TX_ELASTIC) |-> wdata == 8'h00;
  endproperty
  a_elastic: assert property (p_elastic) else $error("bad elastic code");
  property p_tx_code;
    wr && addr == OFF_BASIC_TX |-> wdata[7:4] == 4'h3 || wdata inside {8'h00, 8'h08, 8'h04, 8'h0c};
  endproperty
  a_tx_code: assert property (p_tx_code) else $error("bad transmitter code");
  property p_fdl_match;
    wr && addr == OFF_BASIC_TX && wdata[7:4] == 4'h3 |=> wr_fr && wdata[4] &&
      wdata[3:0] == $past(wdata[3:0]);
  endproperty
  a_fdl_match: assert property (p_fdl_match) else $error("nibble mismatch");
  property p_bit_code;
    wr_fr && wdata[4] |=> wr && addr == OFF_BIT_CODE && (wdata == 8'h00 || wdata == 8'h02);
  endproperty
  a_bit_code: assert property (p_bit_code) else $error("bad code detector write");
  property p_alarm;
    wr && addr == OFF_ALARM_INTEG |-> (fr_seen[4] ? wdata == {4'h1, fr_seen[3:0]} :
      fr_seen == 8'h04 ? wdata inside {8'h04, 8'h0c} : wdata == {4'h0, fr_seen[3:0]});
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm code mismatch");
  sequence s_patterns;
    wr && addr == OFF_LB_ACTIVATE && wdata == 8'h08 ##1
      wr && addr == OFF_LB_DEACTIVATE && wdata == 8'h44;
  endsequence
  property p_loopback;
    wr && addr == OFF_LB_DETECT |-> wdata == 8'h00 ##1 s_patterns;
  endproperty
  a_loopback: assert property (p_loopback) else $error("bad loopback writes");
  property p_signaling;
    wr && addr == OFF_SIG_EXTRACT |-> wdata == {5'h00, fr_seen[4], 2'b00};
  endproperty
  a_signaling: assert property (p_signaling) else $error("bad signaling code");
  c_esf: cover property (wr && addr == OFF_BASIC_TX && wdata[7:4] == 4'h3);
  c_t1dm: cover property (wr_fr && wdata == 8'h04);
  c_loop: cover property (wr_fr && wdata[3:0] == 4'h8 && !wdata[4]);
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/*
  Testbench: AXI4-Lite orders to the controller, device settings checked.
  Assumes the controller and device meet on one configuration interface.
*/
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb
  import tfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, ce = 1;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] axi_wdata = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [6:0]  src = 7'h7f;
  logic [3:0]  bp = 4'h0;
  wire         awready, wready, bvalid, arready, rvalid;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [6:0]   txp;
  wire [5:0]   oe;
  wire [11:0]  k;
  wire [7:0]   bits, lb_act, lb_deact;
  wire [3:0]   sync, tx_fdl, fr_fdl, al_yel;
  wire tfs_format_t tx_fmt, fr_fmt, al_fmt;
  wire tfs_oof_t    fr_oof;
  int          failures = 0, comparisons = 0, cycles = 0;
  tfs_cfg_if cfg_bus ();
  tfs_host i_tfs_host (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cfg(cfg_bus));
  tfs_device i_tfs_device (.aclk(aclk), .aresetn(aresetn), .ce(ce), .cfg(cfg_bus),
    .tx_line_pos_src(src[6:5]), .tx_line_neg_src(src[4:3]), .tx_clock_src(src[2]),
    .tx_data_src(src[1]), .tx_frame_pulse_src(src[0]), .tx_line_pos(txp[6:5]),
    .tx_line_neg(txp[4:3]), .tx_clock_out(txp[2]), .tx_data_out(txp[1]),
    .tx_frame_pulse_out(txp[0]), .rx_backplane_frame_pulse_in(bp[0]),
    .rx_backplane_clock_in(bp[1]), .tx_backplane_frame_pulse_in(bp[2]),
    .tx_backplane_clock_in(bp[3]), .rx_backplane_data_oe(oe[0]),
    .rx_backplane_signaling_oe(oe[1]), .rx_backplane_frame_pulse_oe(oe[2]),
    .rx_backplane_clock_oe(oe[3]), .tx_backplane_frame_pulse_oe(oe[4]),
    .tx_backplane_clock_oe(oe[5]), .backplane_pins_sync(sync), .backplane_rate(k[1:0]),
    .tx_backplane_data_active(k[2]), .tx_backplane_signaling_active(k[3]),
    .rx_elastic_bypass(k[4]), .tx_elastic_bypass(k[5]), .tx_signaling_align(k[6]),
    .tx_fcrc_fdl_bypass(k[7]), .rx_data_link_enable(k[8]), .tx_data_link_enable(k[9]),
    .diagnostics_enable(k[10]), .monitor_counts_frame_alignment_change(k[11]), .rx_line_ami(bits[7]),
    .rx_elastic_frame193(bits[6]), .tx_elastic_frame193(bits[5]), .tx_format(tx_fmt),
    .tx_line_b8zs(bits[4]), .tx_fdl_option(tx_fdl), .framer_format(fr_fmt),
    .framer_oof(fr_oof), .framer_fdl_rate(fr_fdl), .bit_code_4of5(bits[3]),
    .alarm_format(al_fmt), .alarm_alt_red(bits[2]), .alarm_yellow_rate(al_yel),
    .loopback_detect_enable(bits[1]), .loopback_activate(lb_act),
    .loopback_deactivate(lb_deact), .signaling_esf(bits[0]));
  tfs_assertions i_tfs_assertions (.aclk(aclk), .aresetn(aresetn), .addr(cfg_bus.addr),
    .wdata(cfg_bus.wdata), .wr(cfg_bus.wr), .rd(cfg_bus.rd), .rdata(cfg_bus.rdata));
  always #20 aclk = ~aclk;

  task automatic end_of_test();
    $display("Counts: %0d failures, %0d comparisons", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles needed
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      end_of_test();
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit done = 0;
    @(posedge aclk);
    awaddr <= a;
    axi_wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        `CHK(bresp, r)
        done = 1;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
    bit done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        d = rdata;
        `CHK(rresp, r)
        done = 1;
      end
    end
  endtask

  task automatic check_reset();
    `CHK({tx_fmt, fr_fmt, bits[7], bits[4]}, {TFS_FMT_SF, TFS_FMT_SF, 2'b00})
    `CHK(txp, 7'h00)
    `CHK(oe[3:0], 4'h0)
    `CHK({oe[5:4], k[3:0]}, 6'h04)
    `CHK(k[9:4], 6'h02)
    `CHK(k[11:10], 2'b00)
  endtask

  task automatic run_fmt(input logic [31:0] c);
    logic [31:0] d;
    logic [1:0]  f;
    logic [3:0]  x, xf;
    int          n;
    f = c[1:0];
    x = c[7:4];
    xf = (f == TFS_FMT_ESF) ? x : (f == TFS_FMT_T1DM) ? {c[9], 3'b100} :
      (f == TFS_FMT_SLC) ? 4'h8 : 4'h0;
    axi_wr(AXI_CTRL, c, RESP_OKAY);
    axi_wr(AXI_CTRL, c | 32'h8000_0000, RESP_OKAY);
    // Lands while busy, so it must be dropped
    axi_wr(AXI_CTRL, c ^ 32'h1, RESP_OKAY);
    d = '0;
    n = 0;
    while (d[1] !== 1'b1 && n < 40)
    begin
      axi_rd(AXI_STATUS, d, RESP_OKAY);
      n++;
    end
    `CHK(d[1:0], 2'b10)
    axi_rd(AXI_CTRL, d, RESP_OKAY);
    `CHK(d[30:0], c[30:0])
    `CHK(bits[7], f != TFS_FMT_ESF)
    `CHK(bits[6:5], 2'b11)
    `CHK({tx_fmt, bits[4]}, {tfs_format_t'(f), f == TFS_FMT_ESF})
    `CHK(tx_fdl, xf)
    `CHK(fr_fmt, tfs_format_t'(f))
    `CHK(fr_oof, (f == TFS_FMT_T1DM) ? TFS_OOF_4OF12 : tfs_oof_t'(c[3:2]))
    `CHK(fr_fdl, (f == TFS_FMT_ESF) ? x : 4'h0)
    `CHK(al_fmt, tfs_format_t'(f))
    `CHK(bits[2], f == TFS_FMT_T1DM && c[9])
    `CHK({bits[1], lb_act, lb_deact}, {1'b1, 8'h08, 8'h44})
    `CHK(bits[0], f == TFS_FMT_ESF)
    `CHK(txp, src)
    `CHK(al_yel, (f == TFS_FMT_ESF) ? x : 4'h0)
    if (f == TFS_FMT_ESF)
    begin
      `CHK(bits[3], c[8])
    end
  endtask

  // Format order: ESF twice, loop carrier, SF twice, T1DM standard and alternate
  logic [31:0] runs [7] = '{32'h150, 32'h0a8, 32'h005, 32'h00a, 32'h002, 32'h003, 32'h203};

  initial
  begin
    logic [31:0] d;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_reset();
    bp <= 4'ha;
    repeat (2) @(posedge aclk);
    #1;
    `CHK(sync, 4'ha)
    axi_wr(8'h08, 32'h1, RESP_SLVERR);
    axi_wr(AXI_STATUS, 32'h3, RESP_OKAY);
    axi_rd(8'h0c, d, RESP_SLVERR);
    `CHK(d, 32'h0)
    axi_rd(AXI_STATUS, d, RESP_OKAY);
    `CHK(d[1:0], 2'b00)
    foreach (runs[i])
      run_fmt(runs[i]);
    ce <= 1'b0;
    src <= 7'h2a;
    repeat (2) @(posedge aclk);
    #1;
    // Enable low must freeze the pins
    `CHK(txp, 7'h7f)
    @(posedge aclk);
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    `CHK(txp, 7'h2a)
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
